//--- iox_defs.svh
// Constants for the increment / OR / software interrupt execution block
`ifndef IOX_DEFS_SVH
`define IOX_DEFS_SVH

// Widths of the datapath, file address and program counter
`define IOX_DATA_W 8
`define IOX_ADDR_W 6
`define IOX_PC_W   10

// Reset values and fixed operands
`define IOX_DATA_ZERO 8'h00
`define IOX_DATA_ONE  8'h01
`define IOX_ADDR_ZERO 6'h00
`define IOX_PC_ZERO   10'h000
`define IOX_PC_ONE    10'h001

// Vector loaded by the software interrupt
`define IOX_SWINT_VEC 10'h001

`endif

//--- iox_pkg.sv
// Types shared by the increment / OR / software interrupt execution block
package iox_pkg;

  // Instruction selector presented with each request
  typedef enum logic [1:0] {
    OP_INCREMENT_REG,
    OP_INCREMENT_REG_SKIP_ZERO,
    OP_OR_ACC_WITH_REG,
    OP_SWINT
  } iox_op_t;

  // Sequencer states; only the software interrupt leaves IDLE
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SWINT_WAIT,
    ST_SWINT_LOAD
  } iox_state_t;

  // Complete state of the execution block
  typedef struct packed {
    iox_state_t  state;
    logic [9:0]  pc;
    logic [7:0]  accumulator;
    logic        zero_flag;
    logic        skip_pending;
    logic        busy;
    logic        reg_we;
    logic [5:0]  reg_waddr;
    logic [7:0]  reg_wdata;
    logic        stack_push;
    logic [9:0]  stack_data;
  } iox_regs_t;

endpackage : iox_pkg

//--- iox_exec.sv
// Execution unit for increment, increment-skip, OR and software interrupt
// Contract
// - Increment register, result to accumulator or register
// - Increment-skip writes result per destination bit
// - Increment-skip zero result discards next fetched instruction
// - Software interrupt pushes PC+1, vectors to 0x001
// - OR accumulator with register, destination selectable
`timescale 1ns/1ps
`include "iox_defs.svh"

module iox_exec (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  // Instruction request
  input  wire logic                    op_valid,
  input  wire iox_pkg::iox_op_t        op_code,
  input  wire logic [`IOX_ADDR_W-1:0]  op_addr,
  input  wire logic                    op_dest,
  // File register read port (combinational read of op_addr)
  input  wire logic [`IOX_DATA_W-1:0]  reg_rdata,
  // Accumulator load from other instructions
  input  wire logic                    acc_load,
  input  wire logic [`IOX_DATA_W-1:0]  acc_load_data,
  // File register write port
  output logic                         reg_we,
  output logic [`IOX_ADDR_W-1:0]       reg_waddr,
  output logic [`IOX_DATA_W-1:0]       reg_wdata,
  // Core state
  output logic [`IOX_DATA_W-1:0]       accumulator,
  output logic                         zero_flag,
  output logic [`IOX_PC_W-1:0]         pc,
  output logic                         busy,
  output logic                         skip_pending,
  // Stack push port
  output logic                         stack_push,
  output logic [`IOX_PC_W-1:0]         stack_data
);

  // ==========================================================================
  // Request decode
  // ==========================================================================
  iox_pkg::iox_regs_t r_reg;
  iox_pkg::iox_regs_t r_next;
  logic                    take;
  logic                    discard;
  logic [`IOX_DATA_W-1:0]  inc_sum;
  logic [`IOX_DATA_W-1:0]  or_val;

  // A request is accepted only while the sequencer is idle
  assign take    = op_valid && !r_reg.busy;
  assign discard = take && r_reg.skip_pending;
  // 0xff wraps to 0x00 by truncation to the data width
  assign inc_sum = reg_rdata + `IOX_DATA_ONE;
  assign or_val  = r_reg.accumulator | reg_rdata;

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Write strobe and push strobe are single-cycle pulses by default
  always_comb begin
    r_next            = r_reg;
    r_next.reg_we     = 1'b0;
    r_next.stack_push = 1'b0;
    if (acc_load) begin
      r_next.accumulator = acc_load_data;
    end
    unique case (r_reg.state)
      iox_pkg::ST_IDLE: begin
        if (discard) begin
          // Already fetched slot runs as a no-operation
          r_next.skip_pending = 1'b0;
          r_next.pc           = r_reg.pc + `IOX_PC_ONE;
        end else if (take) begin
          r_next.pc = r_reg.pc + `IOX_PC_ONE;
          unique case (op_code)
            iox_pkg::OP_INCREMENT_REG: begin
              r_next.zero_flag = (inc_sum == `IOX_DATA_ZERO);
              if (op_dest) begin
                r_next.reg_we    = 1'b1;
                r_next.reg_waddr = op_addr;
                r_next.reg_wdata = inc_sum;
              end else begin
                r_next.accumulator = inc_sum;
              end
            end
            iox_pkg::OP_INCREMENT_REG_SKIP_ZERO: begin
              // Flag untouched; only the skip reacts to a zero result
              r_next.skip_pending = (inc_sum == `IOX_DATA_ZERO);
              if (op_dest) begin
                r_next.reg_we    = 1'b1;
                r_next.reg_waddr = op_addr;
                r_next.reg_wdata = inc_sum;
              end else begin
                r_next.accumulator = inc_sum;
              end
            end
            iox_pkg::OP_OR_ACC_WITH_REG: begin
              r_next.zero_flag = (or_val == `IOX_DATA_ZERO);
              if (op_dest) begin
                r_next.reg_we    = 1'b1;
                r_next.reg_waddr = op_addr;
                r_next.reg_wdata = or_val;
              end else begin
                r_next.accumulator = or_val;
              end
            end
            iox_pkg::OP_SWINT: begin
              // Return address is the slot after the interrupt opcode
              r_next.stack_push = 1'b1;
              r_next.stack_data = r_reg.pc + `IOX_PC_ONE;
              r_next.busy       = 1'b1;
              r_next.state      = iox_pkg::ST_SWINT_WAIT;
            end
          endcase
        end
      end
      iox_pkg::ST_SWINT_WAIT: begin
        r_next.state = iox_pkg::ST_SWINT_LOAD;
      end
      iox_pkg::ST_SWINT_LOAD: begin
        // Vector load closes the three-cycle interrupt entry
        r_next.pc    = `IOX_SWINT_VEC;
        r_next.busy  = 1'b0;
        r_next.state = iox_pkg::ST_IDLE;
      end
      default: begin
        r_next.state = iox_pkg::ST_IDLE;
        r_next.busy  = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Asynchronous reset to constants only
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      r_reg.state        <= iox_pkg::ST_IDLE;
      r_reg.pc           <= `IOX_PC_ZERO;
      r_reg.accumulator  <= `IOX_DATA_ZERO;
      r_reg.zero_flag    <= 1'b0;
      r_reg.skip_pending <= 1'b0;
      r_reg.busy         <= 1'b0;
      r_reg.reg_we       <= 1'b0;
      r_reg.reg_waddr    <= `IOX_ADDR_ZERO;
      r_reg.reg_wdata    <= `IOX_DATA_ZERO;
      r_reg.stack_push   <= 1'b0;
      r_reg.stack_data   <= `IOX_PC_ZERO;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs come straight from the state register
  assign reg_we       = r_reg.reg_we;
  assign reg_waddr    = r_reg.reg_waddr;
  assign reg_wdata    = r_reg.reg_wdata;
  assign accumulator  = r_reg.accumulator;
  assign zero_flag    = r_reg.zero_flag;
  assign pc           = r_reg.pc;
  assign busy         = r_reg.busy;
  assign skip_pending = r_reg.skip_pending;
  assign stack_push   = r_reg.stack_push;
  assign stack_data   = r_reg.stack_data;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence take_inc_reg_s;
    take && !discard && op_code == iox_pkg::OP_INCREMENT_REG && op_dest;
  endsequence

  sequence take_inc_acc_s;
    take && !discard && !acc_load
      && op_code == iox_pkg::OP_INCREMENT_REG && !op_dest;
  endsequence

  sequence take_skip_s;
    take && !discard && op_code == iox_pkg::OP_INCREMENT_REG_SKIP_ZERO;
  endsequence

  sequence take_swint_s;
    take && !discard && op_code == iox_pkg::OP_SWINT;
  endsequence

  sequence swint_entry_s;
    stack_push && busy ##1 !stack_push && busy
      ##1 pc == `IOX_SWINT_VEC && !busy;
  endsequence

  inc_to_reg_a: assert property (
    take_inc_reg_s |=> reg_we && reg_waddr == $past(op_addr)
      && reg_wdata == $past(inc_sum))
    else $error("increment did not write the register");

  inc_to_acc_a: assert property (
    take_inc_acc_s |=> !reg_we && accumulator == $past(inc_sum))
    else $error("increment did not load the accumulator");

  skip_dest_a: assert property (
    take_skip_s ##0 op_dest |=> reg_we && reg_wdata == $past(inc_sum))
    else $error("increment-skip did not write the register");

  skip_flag_a: assert property (
    take_skip_s |=> skip_pending == ($past(reg_rdata) == 8'hff))
    else $error("skip pending does not match zero result");

  skip_discard_a: assert property (
    discard && !acc_load |=> !reg_we && !skip_pending
      && $stable(accumulator) && $stable(zero_flag))
    else $error("discarded slot had an effect");

  swint_entry_a: assert property (
    take_swint_s |=> stack_data == $past(pc) + `IOX_PC_ONE ##0 swint_entry_s)
    else $error("software interrupt entry sequence wrong");

  or_result_a: assert property (
    take && !discard && op_code == iox_pkg::OP_OR_ACC_WITH_REG && !op_dest
      && !acc_load |=> accumulator == $past(or_val) && !reg_we)
    else $error("OR result not in the accumulator");

  zero_update_a: assert property (
    take && !discard && (op_code == iox_pkg::OP_INCREMENT_REG
      || op_code == iox_pkg::OP_OR_ACC_WITH_REG)
      |=> zero_flag == ($past(op_code) == iox_pkg::OP_INCREMENT_REG
        ? $past(reg_rdata) == 8'hff : $past(or_val) == 8'h00))
    else $error("zero flag wrong after increment or OR");

endmodule : iox_exec

//--- tb.sv
// Self-checking testbench for the increment / OR / software interrupt block
`timescale 1ns/1ps
module tb;
  // ==========================================================================
  // Signals and reference state
  // Expected outcome of one taken request
  typedef struct {logic we; logic [5:0] wa; logic [7:0] wd; logic [7:0] acc;
    logic z; logic [9:0] pc; logic sk; logic push; logic bsy;} iox_note_t;
  logic             core_clk, rstn, op_valid, op_dest, acc_load, tk;
  iox_pkg::iox_op_t op_code;
  logic [5:0]       op_addr, reg_waddr;
  logic [7:0]       reg_rdata, acc_load_data, reg_wdata, accumulator, m_acc;
  logic             reg_we, zero_flag, busy, skip_pending, stack_push;
  logic [9:0]       pc, stack_data, m_pc;
  logic             m_z, m_sk;
  iox_note_t        q[$];
  iox_note_t        mon_e;
  int               error_cnt, samples_checked;

  iox_exec i_dut (.core_clk(core_clk), .rstn(rstn), .op_valid(op_valid),
    .op_code(op_code), .op_addr(op_addr), .op_dest(op_dest),
    .reg_rdata(reg_rdata), .acc_load(acc_load), .acc_load_data(acc_load_data),
    .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata),
    .accumulator(accumulator), .zero_flag(zero_flag), .pc(pc), .busy(busy),
    .skip_pending(skip_pending), .stack_push(stack_push),
    .stack_data(stack_data));

  // ==========================================================================
  // Tasks
  task automatic chk(input string nm, input logic [9:0] ex,
                     input logic [9:0] got);
    samples_checked++;
    if (got !== ex) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic final_report;
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Present one request at the falling edge and note what it must produce
  task automatic issue(input iox_pkg::iox_op_t op, input logic [5:0] a,
                       input logic d, input logic [7:0] rd, input logic ld);
    iox_note_t  e;
    logic [7:0] r;
    logic       accw;
    @(negedge core_clk);
    op_valid = 1'b1;
    op_code = op;
    op_addr = a;
    op_dest = d;
    reg_rdata = rd;
    acc_load = ld;
    acc_load_data = 8'($urandom);
    e = '{1'b0, a, 8'h00, 8'h00, 1'b0, 10'h000, 1'b0, 1'b0, 1'b0};
    r = (op == iox_pkg::OP_OR_ACC_WITH_REG) ? (m_acc | rd) : rd + 8'h01;
    accw = 1'b0;
    if (m_sk) m_sk = 1'b0;
    else if (op == iox_pkg::OP_SWINT) begin
      e.push = 1'b1;
      e.bsy = 1'b1;
    end else begin
      accw = !d;
      e.we = d;
      e.wd = r;
      if (!d) m_acc = r;
      if (op == iox_pkg::OP_INCREMENT_REG_SKIP_ZERO) m_sk = (r == 8'h00);
      else m_z = (r == 8'h00);
    end
    // A discarded or register-bound request leaves the load path free
    if (ld && !accw) m_acc = acc_load_data;
    m_pc = m_pc + 10'h001;
    e.acc = m_acc;
    e.z = m_z;
    e.sk = m_sk;
    e.pc = m_pc;
    q.push_back(e);
    tk = 1'b1;
  endtask : issue

  task automatic idle;
    @(negedge core_clk);
    op_valid = 1'b0;
    acc_load = 1'b0;
    tk = 1'b0;
  endtask : idle

  // Software interrupt; requests offered while busy must be ignored
  task automatic swint;
    int n;
    // A pending skip would swallow the interrupt, so spend it on a filler
    if (m_sk) issue(iox_pkg::OP_INCREMENT_REG, 6'h00, 1'b0, 8'h00, 1'b0);
    issue(iox_pkg::OP_SWINT, 6'h00, 1'b0, 8'h00, 1'b0);
    n = 0;
    repeat (6) begin
      @(negedge core_clk);
      if (busy !== 1'b1) break;
      n++;
      tk = 1'b0;
      op_code = iox_pkg::OP_INCREMENT_REG;
      op_dest = 1'b0;
    end
    op_valid = 1'b0;
    if (n == 6) begin
      error_cnt++;
      final_report();
    end
    chk("busy_cycles", 10'd2, 10'(n));
    chk("pc_vector", 10'h001, pc);
    m_pc = 10'h001;
  endtask : swint

  // ==========================================================================
  // Clock and result watcher
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Result lands one edge after the take; look once it has settled
  always @(posedge core_clk) begin
    if (tk) begin
      #1;
      mon_e = q.pop_front();
      chk("reg_we", 10'(mon_e.we), 10'(reg_we));
      if (mon_e.we)
        chk("reg_waddr", 10'(mon_e.wa), 10'(reg_waddr));
      if (mon_e.we)
        chk("reg_wdata", 10'(mon_e.wd), 10'(reg_wdata));
      chk("accumulator", 10'(mon_e.acc), 10'(accumulator));
      chk("zero_flag", 10'(mon_e.z), 10'(zero_flag));
      chk("pc", mon_e.pc, pc);
      chk("skip_pending", 10'(mon_e.sk), 10'(skip_pending));
      chk("stack_push", 10'(mon_e.push), 10'(stack_push));
      if (mon_e.push) chk("stack_data", mon_e.pc, stack_data);
      chk("busy", 10'(mon_e.bsy), 10'(busy));
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {rstn, op_valid, op_dest, acc_load, tk} = 5'h00;
    op_code = iox_pkg::OP_INCREMENT_REG;
    {op_addr, reg_rdata, acc_load_data} = 22'h000000;
    {m_acc, m_z, m_pc, m_sk} = 20'h00000;
    error_cnt = 0;
    samples_checked = 0;
    void'($urandom(91294));
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    chk("pc_reset", 10'h000, pc);
    rstn = 1'b1;
    // Wrap to zero, instruction beats a load, OR to both places
    issue(iox_pkg::OP_INCREMENT_REG, 6'h3f, 1'b1, 8'hff, 1'b0);
    issue(iox_pkg::OP_INCREMENT_REG, 6'h00, 1'b0, 8'h7f, 1'b1);
    issue(iox_pkg::OP_OR_ACC_WITH_REG, 6'h15, 1'b1, 8'h50, 1'b0);
    issue(iox_pkg::OP_INCREMENT_REG, 6'h20, 1'b0, 8'hff, 1'b0);
    issue(iox_pkg::OP_OR_ACC_WITH_REG, 6'h21, 1'b0, 8'h00, 1'b0);
    // Skip armed, follower arrives late and is dropped; load still acts
    issue(iox_pkg::OP_INCREMENT_REG_SKIP_ZERO, 6'h01, 1'b0, 8'hff, 1'b1);
    idle;
    idle;
    issue(iox_pkg::OP_INCREMENT_REG, 6'h02, 1'b1, 8'h10, 1'b1);
    issue(iox_pkg::OP_INCREMENT_REG_SKIP_ZERO, 6'h02, 1'b1, 8'h10, 1'b0);
    issue(iox_pkg::OP_INCREMENT_REG, 6'h03, 1'b1, 8'h20, 1'b0);
    // Skip armed with the follower right behind it and no load beside it
    issue(iox_pkg::OP_INCREMENT_REG_SKIP_ZERO, 6'h04, 1'b1, 8'hff, 1'b0);
    issue(iox_pkg::OP_INCREMENT_REG, 6'h05, 1'b0, 8'h33, 1'b0);
    swint;
    // Random back-to-back traffic with occasional interrupts
    repeat (60) begin
      issue(iox_pkg::iox_op_t'($urandom_range(2, 0)), 6'($urandom),
            1'($urandom), ($urandom_range(3, 0) == 0) ? 8'hff : 8'($urandom),
            1'($urandom));
      if ($urandom_range(7, 0) == 0) swint;
    end
    idle;
    idle;
    final_report();
  end
endmodule : tb
